// ===== clock_source_switcher_bench.sv
// self-checking bench of the clock source switcher
`timescale 1ns/1ns
module clock_source_switcher_bench;
    logic aclk = 0, aresetn = 0, warm_rst = 0, fail = 0, pll_lock, irq;
    logic [6:0] cfg = 7'h02;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, v, tv;
    logic [3:0] wstrb = 0, osc_tick;
    logic [1:0] bresp, rresp;
    logic [5:0] trim;
    logic [33:0] exp_q[$], msk_q[$], tm;
    cssw_pkg::cssw_osc_ctl_t osc_ctl;
    int fail_count = 0, cmp_count = 0, seed = 32'h7e5f;
    logic [2:0] srcs [4] = '{3'h1, 3'h5, 3'h2, 3'h0};
    always #2 aclk = ~aclk;
    cssw_switcher dut_u (.aclk(aclk), .aresetn(aresetn), .warm_rst(warm_rst), .cfg_straps(cfg),
        .osc_tick(osc_tick), .pll_lock_pin(pll_lock), .clock_fail_pin(fail), .osc_ctl(osc_ctl),
        .rc_trim_field(trim), .irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));
    cssw_osc_model osc_u (.aclk(aclk), .osc_en(osc_ctl.osc_en), .pll_en(osc_ctl.pll_en),
        .osc_tick(osc_tick), .pll_lock(pll_lock));
    task give_verdict;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // ----------------------------------------------------------------
    // axi4-lite master tasks
    // ----------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (n = 0; n < 50 && !(bvalid && bready); n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end
        bready <= 0;
        if (n == 50) begin fail_count++; give_verdict; end
        chk("bresp", {32'h0, bresp}, 34'h0);
    endtask
    task rd(input logic [7:0] a, input logic [33:0] m, input logic [33:0] e, output logic [31:0] q);
        int n;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1;
        rready <= 1;
        for (n = 0; n < 50 && !(rvalid && rready); n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end
        q = rdata;
        rready <= 0;
        if (n == 50) begin fail_count++; give_verdict; end
    endtask
    // watcher compares each read answer against the oldest note
    always @(posedge aclk)
        if (rvalid && rready && exp_q.size() > 0)
        begin
            tm = msk_q.pop_front();
            chk("read", {rresp, rdata} & tm, exp_q.pop_front() & tm);
        end
    task switch_to(input logic [2:0] s, input logic [2:0] c);
        int n;
        wr(cssw_pkg::REG_KEY, cssw_pkg::KEY_HIGH_BYTE, 4'h3);
        wr(cssw_pkg::REG_CTRL, {21'h0, s, 8'h00}, 4'h2);
        wr(cssw_pkg::REG_KEY, cssw_pkg::KEY_LOW_BYTE, 4'h3);
        wr(cssw_pkg::REG_CTRL, 32'h1, 4'h1);
        for (n = 0; n < 4000; n++)
        begin
            rd(cssw_pkg::REG_CTRL, 34'h0, 34'h0, v);
            if (v[0] === 1'b0) break;
        end
        if (n == 4000) begin fail_count++; give_verdict; end
        rd(cssw_pkg::REG_CTRL, 34'h3_0000_7009, {19'h0, c, 12'h000}, v);
    endtask
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        repeat (4) @(posedge aclk);
        rd(cssw_pkg::REG_TUNE, 34'h3_FFFF_FFFF, 34'h0, v);
        tv = $random(seed);
        wr(cssw_pkg::REG_TUNE, tv, 4'hF);
        rd(cssw_pkg::REG_TUNE, 34'h3_FFFF_FFFF, {28'h0, tv[5:0]}, v);
        rd(8'h14, 34'h3_0000_0000, {cssw_pkg::RESP_SLVERR, 32'h0}, v);
        wr(cssw_pkg::REG_CTRL, 32'h0000_0200, 4'h2);
        rd(cssw_pkg::REG_CTRL, 34'h3_0000_0700, 34'h0, v);
        $display("test registers done");
        fail <= 1;
        repeat (4) @(posedge aclk);
        fail <= 0;
        rd(cssw_pkg::REG_CTRL, 34'h3_0000_0008, 34'h8, v);
        foreach (srcs[i])
        begin
            switch_to(srcs[i], srcs[i]);
            chk("clk_sel", {31'h0, osc_ctl.clk_sel}, {31'h0, srcs[i]});
        end
        $display("test switching done");
        wr(cssw_pkg::REG_IRQ_MASK, 32'h7, 4'hF);
        wr(cssw_pkg::REG_IRQ_STAT, 32'h7, 4'hF);
        switch_to(3'h0, 3'h0);
        rd(cssw_pkg::REG_IRQ_STAT, 34'h3_0000_0002, 34'h2, v);
        chk("irq", {33'h0, irq}, 34'h1);
        wr(cssw_pkg::REG_IRQ_STAT, 32'h7, 4'hF);
        repeat (2) @(posedge aclk);
        chk("irq", {33'h0, irq}, 34'h0);
        $display("test abort done");
        warm_rst <= 1;
        @(posedge aclk);
        warm_rst <= 0;
        rd(cssw_pkg::REG_TUNE, 34'h3_FFFF_FFFF, {28'h0, tv[5:0]}, v);
        chk("trim", {28'h0, trim}, {28'h0, tv[5:0]});
        $display("test warm reset done");
        cfg <= 7'h6A;
        aresetn <= 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        repeat (4) @(posedge aclk);
        switch_to(3'h1, 3'h5);
        chk("clk_sel", {31'h0, osc_ctl.clk_sel}, 34'h5);
        $display("test disabled switching done");
        give_verdict;
    end
endmodule

// ===== cssw_osc_model.sv
// oscillator and pll model standing behind the switcher's oscillator controls
`timescale 1ns/1ns
module cssw_osc_model (
    // clock
    input wire logic aclk,
    // controls from the switcher
    input wire logic [3:0] osc_en,
    input wire logic pll_en,
    // oscillator outputs
    output logic [3:0] osc_tick,
    output logic pll_lock
);
    logic [1:0] div [4];
    logic [4:0] lock_cnt;
    // a disabled oscillator stands still low; an enabled one toggles every 3 cycles
    always_ff @(posedge aclk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            div[i] <= (!osc_en[i] || div[i] == 2'h2) ? 2'h0 : div[i] + 2'h1;
            osc_tick[i] <= osc_en[i] && (div[i] == 2'h2 ? !osc_tick[i] : osc_tick[i]);
        end
    end
    // lock follows pll enable after 21 cycles
    always_ff @(posedge aclk)
    begin
        lock_cnt <= pll_en ? (lock_cnt == 5'h14 ? lock_cnt : lock_cnt + 5'h01) : 5'h00;
        pll_lock <= pll_en && lock_cnt == 5'h14;
    end
endmodule

// ===== cssw_pkg.sv
// constants, types and register map of the clock source switcher
package cssw_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TUNE = 8'h04;
    localparam logic [7:0] REG_KEY = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    // unlock keys, arbitrary values
    localparam logic [31:0] KEY_HIGH_BYTE = 32'h0000_5A5A;
    localparam logic [31:0] KEY_LOW_BYTE = 32'h0000_A5A5;
    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int CTRL_REQ_BIT = 0;
    localparam int CTRL_KEEP_BIT = 1;
    localparam int NEW_SOURCE_SELECT_LSB = 8;
    localparam int NEW_SOURCE_SELECT_MSB = 10;
    localparam logic [5:0] TRIM_RESET = 6'h00;
    localparam logic [2:0] SRC_RESET = 3'h0;
    // source codes
    localparam logic [2:0] SRC_FRC = 3'h0;
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_LPX = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;
    // oscillator index into enable and tick vectors
    localparam logic [1:0] OSC_FRC = 2'h0;
    localparam logic [1:0] OSC_PRI = 2'h1;
    localparam logic [1:0] OSC_LPX = 2'h2;
    localparam logic [1:0] OSC_LOW_POWER_RC_OSC = 2'h3;
    localparam logic [1:0] SUBMODE_EXT_CLK = 2'h0;
    // ----------------------------------------------------------------
    // timing counts, in edges of the new source
    // ----------------------------------------------------------------
    localparam logic [10:0] XTAL_STARTUP_TICKS = 11'h400;
    localparam logic [10:0] SWITCH_TICKS = 11'h00A;
    localparam logic [10:0] XTAL_LAST = XTAL_STARTUP_TICKS - 11'h001;
    localparam logic [10:0] SWITCH_LAST = SWITCH_TICKS - 11'h001;
    // interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_REFUSED = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_XTAL = 3'b010,
        ST_PLL = 3'b011,
        ST_COUNT = 3'b100,
        ST_GATE = 3'b101,
        ST_SWAP = 3'b110
    } cssw_state_t;
    typedef struct packed {
        logic switch_enable_cfg;
        logic [2:0] initial_source_cfg;
        logic [1:0] primary_submode_cfg;
        logic wdt_enable;
    } cssw_cfg_t;
    typedef struct packed {
        logic [3:0] osc_en;
        logic pll_en;
        logic [2:0] clk_sel;
        logic clk_gate;
    } cssw_osc_ctl_t;
endpackage

// ===== cssw_switcher.sv
// clock source switcher with fast rc tuning and an axi4-lite register slave
// Function
// R1: tuning and oscillator control keep their values through a warm reset.
// R2: tuning register has a 6-bit trim field; upper bits read zero.
// R3: software may pick any of the six sources, behind an unlock.
// R4: primary submode comes from straps only, never from software.
// R5: switching and fail-safe monitor work only when the enable strap is zero.
// R6: disabled: new select ignored, current status follows initial-source straps.
// R7: disabled: switch request has no effect and reads zero.
// R8: software unlocks high byte, writes new select, unlocks low byte, sets request.
// R9: each control byte accepts a write only right after its unlock key.
// R10: request with new select equal to current aborts and clears request.
// R11: a valid switch start clears pll lock and clock fail status.
// R12: new oscillator is enabled; a starting crystal waits for its startup timer.
// R13: a pll source waits for pll lock before continuing.
// R14: ten edges of the new clock are counted before the swap.
// R15: after the swap request clears and current status takes the new select.
// R16: old source turns off, except kept low-power rc or low-power crystal.
// R17: code keeps running on the old clock during the whole switch.
// R18: software must pass through plain fast rc between the two pll sources.
// R19: the system clock select changes only while the clock is gated off; code: while sw_en is low it follows the initial-source straps ungated.
`timescale 1ns/1ns
module cssw_switcher (
    // clock and resets
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic warm_rst,
    // configuration straps and oscillator status pins
    input wire cssw_pkg::cssw_cfg_t cfg_straps,
    input wire logic [3:0] osc_tick,
    input wire logic pll_lock_pin,
    input wire logic clock_fail_pin,
    // oscillator control and interrupt
    output cssw_pkg::cssw_osc_ctl_t osc_ctl,
    output logic [5:0] rc_trim_field,
    output logic irq,
    // axi4-lite write channels
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read channels
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    function automatic logic [1:0] src_osc(input logic [2:0] src);
        case (src)
            cssw_pkg::SRC_PRI, cssw_pkg::SRC_PRI_PLL: src_osc = cssw_pkg::OSC_PRI;
            cssw_pkg::SRC_LPX: src_osc = cssw_pkg::OSC_LPX;
            cssw_pkg::SRC_LOW_POWER_RC_OSC: src_osc = cssw_pkg::OSC_LOW_POWER_RC_OSC;
            default: src_osc = cssw_pkg::OSC_FRC;
        endcase
    endfunction
    function automatic logic src_pll(input logic [2:0] src);
        src_pll = (src == cssw_pkg::SRC_FRC_PLL) || (src == cssw_pkg::SRC_PRI_PLL);
    endfunction
    function automatic logic src_xtal(input logic [2:0] src, input logic [1:0] submode);
        src_xtal = (src == cssw_pkg::SRC_LPX) || ((src_osc(src) == cssw_pkg::OSC_PRI)
            && (submode != cssw_pkg::SUBMODE_EXT_CLK));
    endfunction

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    cssw_pkg::cssw_cfg_t cfg_s1, cfg_s2;
    logic [3:0] tick_s1, tick_s2, tick_s3;
    logic lock_s1, lock_s2, fail_s1, fail_s2;
    logic [1:0] init_cnt;
    logic init_done, sw_en;
    logic [3:0] osc_edge;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_s1 <= '0;
            cfg_s2 <= '0;
            tick_s1 <= 4'h0;
            tick_s2 <= 4'h0;
            tick_s3 <= 4'h0;
            {lock_s1, lock_s2, fail_s1, fail_s2} <= 4'h0;
        end
        else
        begin
            cfg_s1 <= cfg_straps;
            cfg_s2 <= cfg_s1;
            tick_s1 <= osc_tick;
            tick_s2 <= tick_s1;
            tick_s3 <= tick_s2;
            {lock_s1, lock_s2, fail_s1, fail_s2} <= {pll_lock_pin, lock_s1, clock_fail_pin, fail_s1};
        end
    end
    // straps are trusted once the synchroniser has filled
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            init_cnt <= 2'h0;
        else if (!init_done)
            init_cnt <= init_cnt + 2'h1;
    end
    assign init_done = (init_cnt == 2'h3);
    assign sw_en = init_done && !cfg_s2.switch_enable_cfg; // R5
    assign osc_edge = tick_s2 & ~tick_s3;

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    cssw_pkg::cssw_state_t state;
    logic [2:0] new_source_select, cos, tgt;
    logic [1:0] old_idx;
    logic req, keep_on, lock_st, fail_st, unl_hi, unl_lo;
    logic [10:0] tcnt;
    logic [2:0] irq_stat, irq_mask, ev;
    logic aw_hold, w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire, go, ctrl_wr, hi_ok, lo_ok;
    logic [31:0] rd_word;
    logic rd_hit;

    assign wr_fire = aw_hold && w_hold && !bvalid;
    assign ctrl_wr = wr_fire && (aw_addr == cssw_pkg::REG_CTRL);
    assign hi_ok = ctrl_wr && w_strb[1] && unl_hi; // R9
    assign lo_ok = ctrl_wr && w_strb[0] && unl_lo; // R9
    assign go = (state == cssw_pkg::ST_IDLE) && req && sw_en && (new_source_select != cos);

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            awready <= 1'b0;
            aw_addr <= 8'h00;
        end
        else if (awvalid && awready)
        begin
            aw_hold <= 1'b1;
            awready <= 1'b0;
            aw_addr <= awaddr[7:0];
        end
        else if (wr_fire)
            aw_hold <= 1'b0;
        else if (!aw_hold)
            awready <= 1'b1;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_hold <= 1'b0;
            wready <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (wvalid && wready)
        begin
            w_hold <= 1'b1;
            wready <= 1'b0;
            w_data <= wdata;
            w_strb <= wstrb;
        end
        else if (wr_fire)
            w_hold <= 1'b0;
        else if (!w_hold)
            wready <= 1'b1;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= cssw_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid <= 1'b1;
            bresp <= (aw_addr > cssw_pkg::REG_IRQ_MASK || aw_addr[1:0] != 2'h0) ?
                cssw_pkg::RESP_SLVERR : cssw_pkg::RESP_OKAY;
        end
        else if (bready)
            bvalid <= 1'b0;
    end
    always_comb
    begin
        rd_hit = 1'b1;
        case (araddr[7:0])
            cssw_pkg::REG_CTRL: rd_word = {17'h0_0000, cos, 1'b0, new_source_select, 2'h0, lock_st, 1'b0, fail_st,
                1'b0, keep_on, req && sw_en}; // R7
            cssw_pkg::REG_TUNE: rd_word = {26'h000_0000, rc_trim_field}; // R2
            cssw_pkg::REG_IRQ_STAT: rd_word = {29'h0000_0000, irq_stat};
            cssw_pkg::REG_IRQ_MASK: rd_word = {29'h0000_0000, irq_mask};
            cssw_pkg::REG_KEY: rd_word = 32'h0000_0000;
            default:
            begin
                rd_word = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= cssw_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_hit ? cssw_pkg::RESP_OKAY : cssw_pkg::RESP_SLVERR;
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
        else if (!rvalid)
            arready <= 1'b1;
    end

    // ----------------------------------------------------------------
    // unlock, tuning and control fields (power-on reset only, except unlock and request, which also clear on warm reset)
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn || warm_rst)
        begin
            unl_hi <= 1'b0;
            unl_lo <= 1'b0;
        end
        else if (wr_fire)
        begin
            unl_hi <= (aw_addr == cssw_pkg::REG_KEY) && (w_data == cssw_pkg::KEY_HIGH_BYTE); // R9
            unl_lo <= (aw_addr == cssw_pkg::REG_KEY) && (w_data == cssw_pkg::KEY_LOW_BYTE); // R9
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rc_trim_field <= cssw_pkg::TRIM_RESET; // R1
        else if (wr_fire && aw_addr == cssw_pkg::REG_TUNE && w_strb[0])
            rc_trim_field <= w_data[5:0]; // R2
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            new_source_select <= cssw_pkg::SRC_RESET;
            keep_on <= 1'b0;
        end
        else
        begin
            if (hi_ok)
                new_source_select <= w_data[cssw_pkg::NEW_SOURCE_SELECT_MSB:cssw_pkg::NEW_SOURCE_SELECT_LSB]; // R3
            if (lo_ok)
                keep_on <= w_data[cssw_pkg::CTRL_KEEP_BIT];
        end
    end
    // request: software set tested before hardware clear so a same-cycle software set wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn || warm_rst || !sw_en)
            req <= 1'b0; // R7
        else if (lo_ok && w_data[cssw_pkg::CTRL_REQ_BIT])
            req <= 1'b1;
        else if ((state == cssw_pkg::ST_IDLE && req && new_source_select == cos) || state == cssw_pkg::ST_SWAP)
            req <= 1'b0; // R10 R15
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lock_st <= 1'b0;
            fail_st <= 1'b0;
        end
        else
        begin
            lock_st <= go ? 1'b0 : (lock_st || (lock_s2 && src_pll(cos))); // R11
            fail_st <= (go ? 1'b0 : fail_st) || (fail_s2 && sw_en); // R11
        end
    end

    // ----------------------------------------------------------------
    // switch sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn || warm_rst)
        begin
            state <= cssw_pkg::ST_IDLE;
            tgt <= cssw_pkg::SRC_RESET;
            tcnt <= 11'h000;
            old_idx <= cssw_pkg::OSC_FRC;
        end
        else
        begin
            case (state)
                cssw_pkg::ST_IDLE:
                    if (go)
                    begin
                        tgt <= new_source_select;
                        old_idx <= src_osc(cos);
                        state <= cssw_pkg::ST_START;
                    end
                cssw_pkg::ST_START:
                begin
                    tcnt <= 11'h000;
                    if (src_xtal(tgt, cfg_s2.primary_submode_cfg) && !osc_ctl.osc_en[src_osc(tgt)])
                        state <= cssw_pkg::ST_XTAL; // R12 R4
                    else
                        state <= src_pll(tgt) ? cssw_pkg::ST_PLL : cssw_pkg::ST_COUNT;
                end
                cssw_pkg::ST_XTAL:
                    if (osc_edge[src_osc(tgt)])
                    begin
                        tcnt <= tcnt + 11'h001;
                        if (tcnt == cssw_pkg::XTAL_LAST)
                        begin
                            tcnt <= 11'h000;
                            state <= src_pll(tgt) ? cssw_pkg::ST_PLL : cssw_pkg::ST_COUNT; // R12
                        end
                    end
                cssw_pkg::ST_PLL:
                    if (lock_s2)
                        state <= cssw_pkg::ST_COUNT; // R13
                cssw_pkg::ST_COUNT:
                    if (osc_edge[src_osc(tgt)])
                    begin
                        tcnt <= tcnt + 11'h001;
                        if (tcnt == cssw_pkg::SWITCH_LAST)
                            state <= cssw_pkg::ST_GATE; // R14
                    end
                cssw_pkg::ST_GATE:
                    state <= cssw_pkg::ST_SWAP;
                cssw_pkg::ST_SWAP:
                    state <= cssw_pkg::ST_IDLE;
                default:
                    state <= cssw_pkg::ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cos <= cssw_pkg::SRC_RESET;
        else if (!sw_en)
            cos <= cfg_s2.initial_source_cfg; // R6
        else if (state == cssw_pkg::ST_SWAP)
            cos <= tgt; // R15
    end

    // ----------------------------------------------------------------
    // oscillator enables and glitch-free select
    // ----------------------------------------------------------------
    logic [3:0] next_osc_en;
    always_comb
    begin
        next_osc_en = 4'h0;
        next_osc_en[src_osc(cos)] = 1'b1;
        if (state != cssw_pkg::ST_IDLE)
            next_osc_en[src_osc(tgt)] = 1'b1; // R12 R17
        if (cfg_s2.wdt_enable || sw_en)
            next_osc_en[cssw_pkg::OSC_LOW_POWER_RC_OSC] = 1'b1; // R16
        if (keep_on)
            next_osc_en[cssw_pkg::OSC_LPX] = 1'b1; // R16
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            osc_ctl.osc_en <= 4'h0;
            osc_ctl.pll_en <= 1'b0;
            osc_ctl.clk_sel <= cssw_pkg::SRC_RESET;
            osc_ctl.clk_gate <= 1'b0;
        end
        else
        begin
            osc_ctl.osc_en <= next_osc_en; // R16
            osc_ctl.pll_en <= src_pll(cos) || (state != cssw_pkg::ST_IDLE && src_pll(tgt));
            osc_ctl.clk_gate <= (state != cssw_pkg::ST_GATE) && (state != cssw_pkg::ST_SWAP); // R19
            if (state == cssw_pkg::ST_SWAP || state == cssw_pkg::ST_IDLE && !sw_en)
                osc_ctl.clk_sel <= cos == tgt || !sw_en ? cos : tgt; // R19
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    assign ev[cssw_pkg::IRQ_DONE] = (state == cssw_pkg::ST_SWAP);
    assign ev[cssw_pkg::IRQ_ABORT] = (state == cssw_pkg::ST_IDLE) && req && sw_en && (new_source_select == cos);
    assign ev[cssw_pkg::IRQ_REFUSED] = ctrl_wr && ((w_strb[1] && !unl_hi) || (w_strb[0] && !unl_lo));
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_fire && aw_addr == cssw_pkg::REG_IRQ_STAT && w_strb[0])
                irq_stat <= (irq_stat & ~w_data[2:0]) | ev;
            else
                irq_stat <= irq_stat | ev;
            if (wr_fire && aw_addr == cssw_pkg::REG_IRQ_MASK && w_strb[0])
                irq_mask <= w_data[2:0];
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [3:0] seen;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state != cssw_pkg::ST_COUNT)
            seen <= 4'h0;
        else if (osc_edge[src_osc(tgt)])
            seen <= seen + 4'h1;
    end
    sequence s_gate;
        state == cssw_pkg::ST_GATE ##1 state == cssw_pkg::ST_SWAP;
    endsequence
    sequence s_done;
        state == cssw_pkg::ST_IDLE && osc_ctl.clk_gate;
    endsequence
    a_trim_warm_keep: assert property (warm_rst |=> $stable(rc_trim_field)) else $error("trim changed"); // R1
    a_disabled_req: assert property (!sw_en ##1 !sw_en |-> !req
        && (araddr[7:0] != cssw_pkg::REG_CTRL || !rd_word[0])) else $error("req live"); // R7
    a_disabled_cos: assert property (!sw_en |=> cos == $past(cfg_s2.initial_source_cfg))
        else $error("cos not strap"); // R6
    a_redundant_abort: assert property (state == cssw_pkg::ST_IDLE && req && sw_en && new_source_select == cos
        && !lo_ok |=> !req && state == cssw_pkg::ST_IDLE && $stable(cos)) else $error("no abort"); // R10
    a_start_clears: assert property (go |=> !lock_st && (!fail_st || $past(fail_s2))
        && state == cssw_pkg::ST_START) else $error("lock kept"); // R11
    a_xtal_wait: assert property (state == cssw_pkg::ST_XTAL && !osc_edge[src_osc(tgt)] && !warm_rst
        |=> state == cssw_pkg::ST_XTAL) else $error("xtal left"); // R12
    a_pll_wait: assert property (state == cssw_pkg::ST_PLL && !lock_s2 && !warm_rst
        |=> state == cssw_pkg::ST_PLL) else $error("pll skipped"); // R13
    a_ten_edges: assert property ($rose(state == cssw_pkg::ST_GATE) |-> $past(seen) == 4'h9
        && $past(osc_edge[src_osc(tgt)])) else $error("edge count"); // R14
    a_swap_update: assert property (s_gate |=> cos == $past(tgt) && !req && osc_ctl.clk_sel == $past(tgt))
        else $error("swap update"); // R15
    a_old_off: assert property (state == cssw_pkg::ST_SWAP && !warm_rst && old_idx != src_osc(tgt)
        && old_idx == cssw_pkg::OSC_PRI |-> ##2 !osc_ctl.osc_en[$past(old_idx, 2)])
        else $error("old on"); // R16
    a_sel_gated: assert property (sw_en && $changed(osc_ctl.clk_sel) |-> !osc_ctl.clk_gate ##1 s_done)
        else $error("sel ungated"); // R19
    a_lock_byte: assert property (ctrl_wr && !unl_hi |=> $stable(new_source_select)) else $error("locked write"); // R9
endmodule
